// *** verilog/scl_defs.vh ***
`ifndef SCL_DEFS_VH
`define SCL_DEFS_VH

`define SCL_CLK_HZ 200000000
`define SCL_SLOW_HZ 100000
`define SCL_FAST_HZ 400000
`define SCL_PRESCALE_SLOW (`SCL_CLK_HZ / (4 * `SCL_SLOW_HZ))
`define SCL_PRESCALE_FAST (`SCL_CLK_HZ / (4 * `SCL_FAST_HZ))

`define SCL_DEV_ADDR_HI 3'h5
`define SCL_LOAD_MODES 16'h00ff

`define SCL_TYPE_SINGLE 2'h0
`define SCL_TYPE_SEQ 2'h1
`define SCL_TYPE_BAD 2'h2
`define SCL_TYPE_DONE 2'h3
`define SCL_TYPE_MSB 7
`define SCL_TYPE_LSB 6
`define SCL_ADDR_W 14
`define SCL_SUM_GOOD 8'hff
`define SCL_LAST_BYTE 16'hffff

`define SCL_FIFO_W 46
`define SCL_FIFO_D 4

`endif

// *** verilog/scl_fifo.v ***
`timescale 1ns/10ps
`default_nettype none
module scl_fifo #(
    parameter W = 46,
    parameter D = 4
) (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output reg o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W*D-1:0] mem_q;
    reg [W*D-1:0] mem_d;
    reg [2:0] cnt_q;
    reg [2:0] cnt_d;
    wire push;
    wire pop;
    wire [2:0] wr_idx;
    integer i;

    assign o_in_ready = (cnt_q != D[2:0]);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign wr_idx = cnt_q - {2'h0, pop};
    // head always sits in slot 0 so the read data is a plain flop
    assign o_out_data = mem_q[W-1:0];

    always @* begin
        mem_d = pop ? (mem_q >> W) : mem_q;
        for (i = 0; i < D; i = i + 1) begin
            if (push && wr_idx == i[2:0]) begin
                mem_d[i*W +: W] = i_in_data;
            end
        end
        cnt_d = cnt_q + {2'h0, push} - {2'h0, pop};
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_q <= {(W*D){1'b0}};
            cnt_q <= 3'h0;
            o_out_valid <= 1'b0;
        end else begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            o_out_valid <= (cnt_d != 3'h0);
        end
    end
endmodule
`default_nettype wire

// *** verilog/scl_loader.v ***
`timescale 1ns/10ps
`default_nettype none
`include "scl_defs.vh"
module scl_loader (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_hot_reset,
    input wire i_slow_mode_strap,
    input wire [3:0] i_switch_operating_mode,
    input wire [3:0] i_eeprom_addr_straps,
    input wire i_ignore_sum_errors,
    output reg o_rd_req,
    output reg [6:0] o_rd_dev_addr,
    output reg [15:0] o_rd_byte_addr,
    input wire i_rd_valid,
    input wire i_rd_nack,
    input wire [7:0] i_rd_data,
    output wire o_reg_wr_valid,
    output wire [15:0] o_reg_wr_addr,
    output wire [31:0] o_reg_wr_data,
    input wire i_reg_wr_ready,
    input wire i_reg_wr_unmapped,
    output reg [15:0] o_clock_prescale_field,
    output reg o_busy,
    output reg o_load_done,
    output reg o_halt_after_reset,
    output reg o_unmapped_write_flag,
    output reg o_sum_error_flag,
    output reg o_nack_error_flag
);
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_REQ = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;
    localparam [1:0] S_DRAIN = 2'h3;
    localparam [1:0] P_HDR = 2'h0;
    localparam [1:0] P_CNT = 2'h1;
    localparam [1:0] P_DATA = 2'h2;
    localparam [31:0] PS_SLOW_W = `SCL_PRESCALE_SLOW;
    localparam [31:0] PS_FAST_W = `SCL_PRESCALE_FAST;
    localparam [15:0] PS_SLOW = PS_SLOW_W[15:0];
    localparam [15:0] PS_FAST = PS_FAST_W[15:0];
    localparam [15:0] LOAD_MODES = `SCL_LOAD_MODES;

    reg [1:0] state_q;
    reg [1:0] phase_q;
    reg [1:0] bidx_q;
    reg [7:0] sum_q;
    reg [7:0] lo_q;
    reg [`SCL_ADDR_W-1:0] dw_addr_q;
    reg [15:0] dword_count_q;
    reg [31:0] data_q;
    reg strap_taken_q;
    reg err_q;
    reg fifo_push;
    wire fifo_in_ready;
    wire [`SCL_FIFO_W-1:0] fifo_out;
    wire [7:0] sum_next;
    wire [31:0] word_next;
    wire start;

    function mode_loads;
        input [3:0] mode;
        begin
            mode_loads = LOAD_MODES[mode];
        end
    endfunction

    assign sum_next = sum_q + i_rd_data;
    assign word_next = {i_rd_data, data_q[31:8]};
    assign start = ((!strap_taken_q) || i_hot_reset)
        && mode_loads(i_switch_operating_mode);
    assign o_reg_wr_addr = {fifo_out[`SCL_FIFO_W-1:32], 2'b00};
    assign o_reg_wr_data = fifo_out[31:0];

    // one dword per entry, pushed in image order; stalls reads when full
    scl_fifo #(
        .W(`SCL_FIFO_W),
        .D(`SCL_FIFO_D)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data({dw_addr_q, word_next}),
        .o_out_valid(o_reg_wr_valid),
        .i_out_ready(i_reg_wr_ready),
        .o_out_data(fifo_out)
    );

    always @* begin
        fifo_push = (state_q == S_WAIT) && i_rd_valid && !i_rd_nack
            && (phase_q == P_DATA) && (bidx_q == 2'h3);
    end

    // strap caught at the first edge after release, never by the reset itself
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_taken_q <= 1'b0;
            o_clock_prescale_field <= PS_FAST;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            o_clock_prescale_field <= i_slow_mode_strap ? PS_SLOW : PS_FAST;
        end
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_unmapped_write_flag <= 1'b0;
        end else if (o_reg_wr_valid && i_reg_wr_ready && i_reg_wr_unmapped) begin
            o_unmapped_write_flag <= 1'b1;
        end else if (start) begin
            o_unmapped_write_flag <= 1'b0;
        end
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= S_IDLE;
            phase_q <= P_HDR;
            bidx_q <= 2'h0;
            sum_q <= 8'h00;
            lo_q <= 8'h00;
            dw_addr_q <= {`SCL_ADDR_W{1'b0}};
            dword_count_q <= 16'h0000;
            data_q <= 32'h00000000;
            err_q <= 1'b0;
            o_rd_req <= 1'b0;
            o_rd_dev_addr <= 7'h00;
            o_rd_byte_addr <= 16'h0000;
            o_busy <= 1'b0;
            o_load_done <= 1'b0;
            o_halt_after_reset <= 1'b0;
            o_sum_error_flag <= 1'b0;
            o_nack_error_flag <= 1'b0;
        end else if (start) begin
            // a restart drops any read in flight so the new address never rides an old request
            o_rd_req <= 1'b0;
            state_q <= S_REQ;
            phase_q <= P_HDR;
            bidx_q <= 2'h0;
            sum_q <= 8'h00;
            err_q <= 1'b0;
            o_rd_dev_addr <= {`SCL_DEV_ADDR_HI, i_eeprom_addr_straps};
            o_rd_byte_addr <= 16'h0000;
            o_busy <= 1'b1;
            o_load_done <= 1'b0;
            o_halt_after_reset <= 1'b0;
            o_sum_error_flag <= 1'b0;
            o_nack_error_flag <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    o_rd_req <= 1'b0;
                end
                S_REQ: begin
                    // room is checked before the read so a finished dword never waits
                    if (fifo_in_ready) begin
                        o_rd_req <= 1'b1;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (i_rd_valid) begin
                        o_rd_req <= 1'b0;
                        state_q <= S_REQ;
                        sum_q <= sum_next;
                        bidx_q <= bidx_q + 2'h1;
                        // 16-bit byte address, part of at most 64 KB
                        o_rd_byte_addr <= o_rd_byte_addr + 16'h0001;
                        if (i_rd_nack) begin
                            err_q <= 1'b1;
                            o_nack_error_flag <= 1'b1;
                            state_q <= S_DRAIN;
                        end else begin
                            case (phase_q)
                                P_HDR: begin
                                    if (bidx_q == 2'h0) begin
                                        lo_q <= i_rd_data;
                                    end else begin
                                        bidx_q <= 2'h0;
                                        dw_addr_q <= {i_rd_data[5:0], lo_q};
                                        case (i_rd_data[`SCL_TYPE_MSB:`SCL_TYPE_LSB])
                                            `SCL_TYPE_SINGLE: begin
                                                phase_q <= P_DATA;
                                                dword_count_q <= 16'h0001;
                                            end
                                            `SCL_TYPE_SEQ: begin
                                                phase_q <= P_CNT;
                                            end
                                            `SCL_TYPE_BAD: begin
                                                err_q <= 1'b1;
                                                o_sum_error_flag <= 1'b1;
                                                state_q <= S_DRAIN;
                                            end
                                            default: begin
                                                // done block ends the image
                                                state_q <= S_DRAIN;
                                                if ((sum_next != `SCL_SUM_GOOD)
                                                    && !i_ignore_sum_errors) begin
                                                    err_q <= 1'b1;
                                                    o_sum_error_flag <= 1'b1;
                                                end
                                            end
                                        endcase
                                    end
                                end
                                P_CNT: begin
                                    if (bidx_q == 2'h0) begin
                                        lo_q <= i_rd_data;
                                    end else begin
                                        bidx_q <= 2'h0;
                                        dword_count_q <= {i_rd_data, lo_q};
                                        // a zero count carries no data
                                        phase_q <= ({i_rd_data, lo_q} == 16'h0000)
                                            ? P_HDR : P_DATA;
                                    end
                                end
                                default: begin
                                    data_q <= word_next;
                                    if (bidx_q == 2'h3) begin
                                        dw_addr_q <= dw_addr_q + {{(`SCL_ADDR_W-1){1'b0}}, 1'b1};
                                        dword_count_q <= dword_count_q - 16'h0001;
                                        if (dword_count_q == 16'h0001) begin
                                            phase_q <= P_HDR;
                                        end
                                    end
                                end
                            endcase
                            if (o_rd_byte_addr == `SCL_LAST_BYTE) begin
                                state_q <= S_DRAIN;
                            end
                        end
                    end
                end
                default: begin
                    // done is reported only once every queued write has left
                    o_rd_req <= 1'b0;
                    if (!o_reg_wr_valid) begin
                        state_q <= S_IDLE;
                        o_busy <= 1'b0;
                        o_load_done <= 1'b1;
                        o_halt_after_reset <= err_q;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** tb/scl_loader_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "scl_defs.vh"
module scl_loader_sva (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_switch_operating_mode,
    input wire logic o_rd_req,
    input wire logic [15:0] o_rd_byte_addr,
    input wire logic i_rd_valid,
    input wire logic o_reg_wr_valid,
    input wire logic [15:0] o_reg_wr_addr,
    input wire logic [31:0] o_reg_wr_data,
    input wire logic i_reg_wr_ready,
    input wire logic i_reg_wr_unmapped,
    input wire logic o_busy,
    input wire logic o_load_done,
    input wire logic o_sum_error_flag,
    input wire logic o_nack_error_flag,
    input wire logic o_unmapped_write_flag
);
    localparam logic [15:0] LOAD_MODES = `SCL_LOAD_MODES;
    logic [15:0] nxt_q;
    // idle rearms the expected address, so a restart must begin at zero
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) nxt_q <= 16'h0000;
        else if (!o_busy) nxt_q <= 16'h0000;
        else if (o_rd_req && i_rd_valid) nxt_q <= o_rd_byte_addr + 16'h0001;
    end
    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    a_req_hold: assert property (o_rd_req && !i_rd_valid
        |=> o_rd_req && $stable(o_rd_byte_addr))
        else $error("read request not held");
    a_req_gap: assert property (o_rd_req && i_rd_valid |=> !o_rd_req)
        else $error("read request held past answer");
    a_addr_seq: assert property (o_rd_req |-> o_rd_byte_addr == nxt_q)
        else $error("byte address out of sequence");
    a_mode_gate: assert property (!LOAD_MODES[i_switch_operating_mode] |-> !o_busy)
        else $error("load in a mode without it");
    a_err_done: assert property ($rose(o_sum_error_flag) || $rose(o_nack_error_flag)
        |-> ##[0:300] o_load_done)
        else $error("error without load done");
    a_done_idle: assert property (o_load_done
        |-> !o_busy && !o_rd_req && !o_reg_wr_valid)
        else $error("activity after load done");
    a_unmapped_flag: assert property (o_reg_wr_valid && i_reg_wr_ready && i_reg_wr_unmapped
        |=> o_unmapped_write_flag)
        else $error("unmapped write not flagged");
    a_wr_hold: assert property (o_reg_wr_valid && !i_reg_wr_ready
        |=> o_reg_wr_valid && $stable({o_reg_wr_addr, o_reg_wr_data}))
        else $error("pending write changed");
    a_wr_align: assert property (o_reg_wr_valid |-> o_reg_wr_addr[1:0] == 2'h0)
        else $error("write address not dword aligned");
    c_clean: cover property (o_load_done && !o_sum_error_flag && !o_nack_error_flag);
    c_full: cover property (o_reg_wr_valid && !i_reg_wr_ready && !o_rd_req);
    c_nack: cover property ($rose(o_nack_error_flag));
endmodule
bind scl_loader scl_loader_sva chk (.i_sys_clk, .i_reset_n, .i_switch_operating_mode, .o_rd_req,
    .o_rd_byte_addr, .i_rd_valid, .o_reg_wr_valid, .o_reg_wr_addr, .o_reg_wr_data, .i_reg_wr_ready,
    .i_reg_wr_unmapped, .o_busy, .o_load_done, .o_sum_error_flag, .o_nack_error_flag,
    .o_unmapped_write_flag);
`default_nettype wire

// *** tb/scl_eeprom_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module scl_eeprom_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic [6:0] i_dev_addr,
    input wire logic [15:0] i_byte_addr,
    output logic o_valid,
    output logic o_nack,
    output logic [7:0] o_data
);
    // sized as the largest part; blank cells read as ones
    logic [7:0] mem [0:65535] = '{default: 8'hff};
    logic [6:0] own_addr = 7'h5a;
    int lat = 0, nack_at = -1, wait_q;
    wire logic go = i_req && !o_valid && wait_q >= lat;
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_valid <= 1'b0;
            o_data <= 8'h00;
            wait_q <= 0;
        end else begin
            o_valid <= go;
            // released line toggles so a stale byte never passes for a fresh one
            o_data <= go ? mem[i_byte_addr] : ~o_data;
            wait_q <= (i_req && !o_valid) ? wait_q + 1 : 0;
        end
    end
    // a part that does not own the bus address never acknowledges
    assign o_nack = o_valid && (i_dev_addr != own_addr || int'(i_byte_addr) == nack_at);
endmodule
`default_nettype wire

// *** tb/tb_smbus_eeprom_config_loader.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_smbus_eeprom_config_loader;
    logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_hot_reset = 1'b0, i_slow_mode_strap = 1'b1;
    logic i_ignore_sum_errors = 1'b0, i_reg_wr_ready = 1'b0, i_reg_wr_unmapped = 1'b0;
    logic [3:0] i_switch_operating_mode = 4'h0, i_eeprom_addr_straps = 4'ha;
    wire logic o_rd_req, i_rd_valid, i_rd_nack, o_reg_wr_valid, o_busy, o_load_done;
    wire logic o_halt_after_reset, o_unmapped_write_flag, o_sum_error_flag, o_nack_error_flag;
    wire logic [6:0] o_rd_dev_addr;
    wire logic [7:0] i_rd_data;
    wire logic [15:0] o_rd_byte_addr, o_reg_wr_addr, o_clock_prescale_field;
    wire logic [31:0] o_reg_wr_data;
    int fail_count = 0, num_checks = 0, stall = 0, p = 0, n;
    logic [7:0] sum = 8'h00;
    logic [47:0] exp_q[$];
    logic [47:0] want;
    scl_loader uut (.i_sys_clk, .i_reset_n, .i_hot_reset, .i_slow_mode_strap,
        .i_switch_operating_mode, .i_eeprom_addr_straps, .i_ignore_sum_errors, .o_rd_req,
        .o_rd_dev_addr, .o_rd_byte_addr, .i_rd_valid, .i_rd_nack, .i_rd_data, .o_reg_wr_valid,
        .o_reg_wr_addr, .o_reg_wr_data, .i_reg_wr_ready, .i_reg_wr_unmapped,
        .o_clock_prescale_field, .o_busy, .o_load_done, .o_halt_after_reset,
        .o_unmapped_write_flag, .o_sum_error_flag, .o_nack_error_flag);
    scl_eeprom_model ee (.i_sys_clk, .i_reset_n, .i_req(o_rd_req), .i_dev_addr(o_rd_dev_addr),
        .i_byte_addr(o_rd_byte_addr), .o_valid(i_rd_valid), .o_nack(i_rd_nack),
        .o_data(i_rd_data));
    initial forever #2.5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] seen);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // register sink: stalls on request, flags the one unmapped target
    always @(negedge i_sys_clk) begin
        i_reg_wr_ready <= (stall == 0);
        i_reg_wr_unmapped <= (o_reg_wr_addr == 16'hfffc);
        if (stall > 0) stall <= stall - 1;
    end
    always @(posedge i_sys_clk) begin
        if (o_reg_wr_valid === 1'b1 && i_reg_wr_ready === 1'b1) begin
            want = exp_q.size() ? exp_q.pop_front() : 48'hx;
            chk("reg write", want, {o_reg_wr_addr, o_reg_wr_data});
        end
    end
    task automatic put(input logic [7:0] b);
        ee.mem[p] = b;
        sum += b;
        p++;
    endtask
    task automatic hdr(input logic [13:0] a, input logic [1:0] t);
        put(a[7:0]);
        put({t, a[13:8]});
    endtask
    task automatic dw(input logic [31:0] d);
        for (int i = 0; i < 4; i++) put(d[8*i +: 8]);
    endtask
    task automatic single(input logic [13:0] a, input logic [31:0] d);
        hdr(a, 2'h0);
        dw(d);
        exp_q.push_back({a, 2'h0, d});
    endtask
    task automatic seq(input logic [13:0] a, input logic [15:0] c, input logic [31:0] d);
        hdr(a, 2'h1);
        put(c[7:0]);
        put(c[15:8]);
        for (int i = 0; i < c; i++) begin
            dw(d + 32'(i));
            exp_q.push_back({a + 14'(i), 2'h0, d + 32'(i)});
        end
    endtask
    // a corrupt image flips one checksum bit; the next image starts afresh
    task automatic done(input logic ok);
        put(~(sum + 8'hc0) ^ {7'h00, !ok});
        put(8'hc0);
        p = 0;
        sum = 8'h00;
    endtask
    task automatic start(input logic hot);
        if (hot) begin
            i_hot_reset = 1'b1;
            @(negedge i_sys_clk);
            i_hot_reset = 1'b0;
        end else begin
            i_reset_n = 1'b0;
            repeat (2) @(negedge i_sys_clk);
            i_reset_n = 1'b1;
        end
        repeat (3) @(negedge i_sys_clk);
    endtask
    task automatic settle(input logic [4:0] f);
        for (n = 0; n < 4000 && o_load_done !== 1'b1; n++) @(negedge i_sys_clk);
        if (n == 4000) begin
            fail_count++;
            $display("wrong value load done expected 1 seen 0");
            close_out();
        end
        chk("done halt sum nack unmapped", f, {o_load_done, o_halt_after_reset,
            o_sum_error_flag, o_nack_error_flag, o_unmapped_write_flag});
        chk("writes left", 0, exp_q.size());
        exp_q.delete();
    endtask
    initial begin
        ee.lat = 3;
        single(14'h0010, 32'h11223344);
        seq(14'h0020, 16'h0003, 32'ha0b0c0d0);
        single(14'h3fff, 32'hdeadbeef);
        done(1'b1);
        stall = 400;
        start(1'b0);
        settle(5'h11);
        chk("prescale", 16'h01f4, o_clock_prescale_field);
        single(14'h0001, 32'h00c0ffee);
        done(1'b0);
        i_slow_mode_strap = 1'b0;
        ee.lat = 0;
        start(1'b0);
        settle(5'h1c);
        chk("prescale", 16'h007d, o_clock_prescale_field);
        seq(14'h0100, 16'h0001, 32'h5a5a0001);
        done(1'b0);
        i_ignore_sum_errors = 1'b1;
        start(1'b1);
        settle(5'h10);
        i_ignore_sum_errors = 1'b0;
        hdr(14'h0004, 2'h2);
        dw(32'h00000000);
        done(1'b1);
        start(1'b1);
        settle(5'h1c);
        single(14'h0008, 32'h00000001);
        done(1'b1);
        exp_q.delete();
        ee.nack_at = 2;
        start(1'b1);
        settle(5'h1a);
        i_switch_operating_mode = 4'h8;
        start(1'b1);
        n = 0;
        repeat (40) begin
            @(negedge i_sys_clk);
            if (o_busy !== 1'b0) n++;
        end
        chk("busy in plain mode", 0, n);
        close_out();
    end
endmodule
`default_nettype wire
